// ---- dsfs_pkg.sv ----
// Package of constants and types for the drive state and fault sequencer
// Operation
// - Class 0 error: warning only, motion continues
// - Class 1 error: quick stop, amplifier stays on
// - Class 2 error: quick stop, off at standstill
// - Class 3 error: switch off immediately, no braking
// - Class 4 error: off, only power cycle clears
// - Keep last cause and last ten errors
// - Nine numbered operating states, start through fault
// - Start to not ready on init or low speed
// - Not ready to disabled after first commissioning
// - Disabled to ready: encoder, bus, speed under 1000
// - Enable rising edge: ready to switched on
// - Switched on to enabled if enable still set
// - Ready to disabled on undervoltage or overspeed
// - Enable falling edge in 5/6 returns to 3
// - Class 1 error in 6 enters quick stop
// - Enable falls in 7: to 3, amplifier off
// - Class 2-4 error: any state to fault reaction
// - Fault reaction done: enter fault state
// - Fault reset in fault state returns to 3, except while the class 4 lock is set
// - Fault reset in quick stop resumes operation
// - Halt stops motor, no log entries
// - Class 1 logged to cause and history
package dsfs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_CAUSE = 8'h08;
  localparam logic [7:0] OFS_HCNT  = 8'h0c;
  localparam logic [7:0] OFS_HSEL  = 8'h10;
  localparam logic [7:0] OFS_HDATA = 8'h14;

  // Control and status field positions
  localparam int unsigned CTRL_FRST_BIT = 0;
  localparam int unsigned CTRL_HALT_BIT = 1;
  localparam int unsigned STAT_WARN_BIT = 8;
  localparam int unsigned STAT_LOCK_BIT = 9;
  localparam int unsigned STAT_PA_BIT   = 10;
  localparam int unsigned STAT_QS_BIT   = 11;
  localparam int unsigned STAT_EN_BIT   = 12;

  // Error classes
  localparam logic [2:0] CLS_WARN  = 3'h0;
  localparam logic [2:0] CLS_QSTOP = 3'h1;
  localparam logic [2:0] CLS_QSOFF = 3'h2;
  localparam logic [2:0] CLS_FATAL = 3'h3;
  localparam logic [2:0] CLS_UNCTL = 3'h4;

  // History depth and speed limit
  localparam logic [3:0]  HIST_DEPTH    = 4'ha;
  localparam logic [15:0] SPD_LIMIT_RPM = 16'h03e8;

  // Bus answers and reset values
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] CAUSE_RST   = 16'h0000;

  typedef enum logic [3:0] {
    ST_START, ST_NOT_READY, ST_SW_DIS, ST_READY, ST_SW_ON,
    ST_OP_EN, ST_QSTOP, ST_FLT_REACT, ST_FAULT
  } dsfs_state_t;

  // Conditions reported by the drive monitors
  typedef struct packed {
    logic        init_done;
    logic        speed_low;
    logic        commissioned;
    logic        enc_ok;
    logic        dcbus_ok;
    logic        standstill;
    logic        checks_ok;
    logic [15:0] speed_rpm;
  } dsfs_mon_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  cls;
    logic [15:0] code;
  } dsfs_err_t;

  typedef struct packed {
    logic [2:0]  cls;
    logic [15:0] code;
  } dsfs_hent_t;

  // Commands to the power stage
  typedef struct packed {
    logic power_amp;
    logic brake_rel;
    logic quick_stop;
    logic motion_stop;
  } dsfs_drv_t;

  // Displayed state number 1 to 9
  function automatic logic [3:0] dsfs_state_num(input dsfs_state_t s);
    logic [3:0] n;
    n = 4'h0;
    unique case (s)
      ST_START:     n = 4'h1;
      ST_NOT_READY: n = 4'h2;
      ST_SW_DIS:    n = 4'h3;
      ST_READY:     n = 4'h4;
      ST_SW_ON:     n = 4'h5;
      ST_OP_EN:     n = 4'h6;
      ST_QSTOP:     n = 4'h7;
      ST_FLT_REACT: n = 4'h8;
      ST_FAULT:     n = 4'h9;
    endcase
    return n;
  endfunction

endpackage

// ---- dsfs_hist_mem.sv ----
// Error history memory with registered read data
`timescale 1ns/1ps
module dsfs_hist_mem
  import dsfs_pkg::*;
(
  input  wire logic       aclk,    // Clock
  input  wire logic       we,      // Write strobe
  input  wire logic [3:0] waddr,   // Write slot
  input  wire dsfs_hent_t wdata,   // Entry written
  input  wire logic [3:0] raddr,   // Read slot
  output dsfs_hent_t      rdata_q  // Entry read, one cycle late
);

  dsfs_hent_t mem [HIST_DEPTH];

  // Write port; slots past the depth are dropped
  always_ff @(posedge aclk) begin
    if (we && (waddr < HIST_DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read; out of range reads zero
  always_ff @(posedge aclk) begin
    if (raddr < HIST_DEPTH) begin
      rdata_q <= mem[raddr];
    end else begin
      rdata_q <= '0;
    end
  end

endmodule

// ---- dsfs_sequencer.sv ----
// Operating state and fault sequencer with AXI4-Lite registers
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dsfs_sequencer
  import dsfs_pkg::*;
(
  input  wire logic        aclk,          // Clock, 40 MHz
  input  wire logic        aresetn,       // Synchronous reset, low
  input  wire logic        enable_pin,    // Enable from controller
  input  wire logic        frst_pin,      // Fault reset from controller
  input  wire dsfs_mon_t   mon,           // Drive monitor conditions
  input  wire dsfs_err_t   err,           // Error event, one cycle
  output dsfs_drv_t        drv_q,         // Power stage commands
  output logic [3:0]       state_num_q,   // State number 1..9
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready   // Read data ready
);

  dsfs_state_t state_q, state_d;
  logic [2:0]  react_q, react_d;
  logic        lock_q;
  logic [2:0]  en_sync_q, fr_sync_q;
  logic        en_s, en_rise, en_fall, fr_req, pin_fr;
  logic        hi_err, qs_err, react_done;
  logic        halt_q, warn_q, ctrl_fr_q;
  logic [15:0] cause_q;
  logic [3:0]  wptr_q, hcnt_q, hsel_q;
  dsfs_hent_t  hrd;
  dsfs_drv_t   drv_d;
  logic        aw_full_q, w_full_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_wr;
  logic [31:0] rd_mux;
  logic        rd_ok;

  // Pins cross into the clock domain through two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_sync_q <= 3'h0;
      fr_sync_q <= 3'h0;
    end else begin
      en_sync_q <= {en_sync_q[1:0], enable_pin};
      fr_sync_q <= {fr_sync_q[1:0], frst_pin};
    end
  end

  // Edges seen only from the settled stages
  assign en_s    = en_sync_q[1];
  assign en_rise = en_sync_q[1] && !en_sync_q[2];
  assign en_fall = !en_sync_q[1] && en_sync_q[2];
  assign pin_fr  = fr_sync_q[1] && !fr_sync_q[2];
  assign fr_req  = pin_fr || ctrl_fr_q;

  // Error grading; classes above 4 are ignored
  assign hi_err = err.valid && (err.cls >= CLS_QSOFF) && (err.cls <= CLS_UNCTL);
  assign qs_err = err.valid && (err.cls == CLS_QSTOP);
  assign react_done = (react_q == CLS_QSOFF) ? mon.standstill : 1'b1;

  // Next state; a heavy error overrides every other transition
  always_comb begin
    state_d = state_q;
    react_d = react_q;
    unique case (state_q)
      ST_START: begin
        if (mon.init_done || mon.speed_low) state_d = ST_NOT_READY;
      end
      ST_NOT_READY: begin
        if (mon.commissioned) state_d = ST_SW_DIS;
      end
      ST_SW_DIS: begin
        if (mon.enc_ok && mon.dcbus_ok && (mon.speed_rpm < SPD_LIMIT_RPM)) state_d = ST_READY;
      end
      ST_READY: begin
        if (!mon.dcbus_ok || (mon.speed_rpm > SPD_LIMIT_RPM)) begin
          state_d = ST_SW_DIS;
        end else if (en_rise) begin
          state_d = ST_SW_ON;
        end
      end
      ST_SW_ON: begin
        if (en_fall) begin
          state_d = ST_SW_DIS;
        end else if (en_s && mon.checks_ok) begin
          state_d = ST_OP_EN;
        end
      end
      ST_OP_EN: begin
        if (en_fall) begin
          state_d = ST_SW_DIS;
        end else if (qs_err) begin
          state_d = ST_QSTOP;
        end
      end
      ST_QSTOP: begin
        if (en_fall) begin
          state_d = ST_SW_DIS;
        end else if (fr_req) begin
          state_d = ST_OP_EN;
        end
      end
      ST_FLT_REACT: begin
        if (react_done) state_d = ST_FAULT;
      end
      ST_FAULT: begin
        if (fr_req && !lock_q) begin
          state_d = ST_SW_DIS;
          react_d = CLS_WARN;
        end
      end
    endcase
    if (hi_err) begin
      state_d = ST_FLT_REACT;
      // Keep the harsher of a running and a new reaction
      if (!((state_q == ST_FLT_REACT) && (react_q > err.cls))) react_d = err.cls;
    end
  end

  // State register; reset restarts the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_START;
      react_q <= CLS_WARN;
    end else begin
      state_q <= state_d;
      react_q <= react_d;
    end
  end

  // Class 4 lock survives fault resets; only reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (hi_err && (err.cls == CLS_UNCTL)) begin
      lock_q <= 1'b1;
    end
  end

  // Power stage commands follow the next state, so they change with it
  always_comb begin
    drv_d = '0;
    drv_d.power_amp = (state_d == ST_OP_EN) || (state_d == ST_QSTOP)
                   || ((state_d == ST_FLT_REACT) && (react_d == CLS_QSOFF)
                       && !mon.standstill && drv_q.power_amp);
    drv_d.brake_rel = drv_d.power_amp;
    drv_d.quick_stop = (state_d == ST_QSTOP)
                    || ((state_d == ST_FLT_REACT) && (react_d == CLS_QSOFF));
    drv_d.motion_stop = (state_d == ST_OP_EN) && halt_q;
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_q       <= '0;
      state_num_q <= 4'h1;
    end else begin
      drv_q       <= drv_d;
      state_num_q <= dsfs_state_num(state_d);
    end
  end

  // Last interruption cause, class 1 and up; halt never writes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= CAUSE_RST;
    end else if (err.valid && (err.cls >= CLS_QSTOP) && (err.cls <= CLS_UNCTL)) begin
      cause_q <= err.code;
    end
  end

  // History ring of the newest ten messages, warnings included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_q <= 4'h0;
      hcnt_q <= 4'h0;
    end else if (err.valid && (err.cls <= CLS_UNCTL)) begin
      wptr_q <= (wptr_q == HIST_DEPTH - 4'h1) ? 4'h0 : wptr_q + 4'h1;
      if (hcnt_q != HIST_DEPTH) hcnt_q <= hcnt_q + 4'h1;
    end
  end

  dsfs_hist_mem u_hist (
    .aclk    (aclk),
    .we      (err.valid && (err.cls <= CLS_UNCTL)),
    .waddr   (wptr_q),
    .wdata   ({err.cls, err.code}),
    .raddr   (hsel_q),
    .rdata_q (hrd)
  );

  // Write address and data are caught independently
  assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ((awaddr_q == OFS_CTRL) || (awaddr_q == OFS_STAT) || (awaddr_q == OFS_HSEL))
                        ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full_q     <= 1'b0;
        w_full_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control writes; fault reset bit is a one-cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_q    <= 1'b0;
      ctrl_fr_q <= 1'b0;
      hsel_q    <= 4'h0;
    end else begin
      ctrl_fr_q <= do_wr && (awaddr_q == OFS_CTRL) && wstrb_q[0] && wdata_q[CTRL_FRST_BIT];
      if (do_wr && (awaddr_q == OFS_CTRL) && wstrb_q[0]) halt_q <= wdata_q[CTRL_HALT_BIT];
      if (do_wr && (awaddr_q == OFS_HSEL) && wstrb_q[0]) hsel_q <= wdata_q[3:0];
    end
  end

  // Warning flag: write one to clear, a new warning wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_q <= 1'b0;
    end else if (err.valid && (err.cls == CLS_WARN)) begin
      warn_q <= 1'b1;
    end else if (do_wr && (awaddr_q == OFS_STAT) && wstrb_q[1] && wdata_q[STAT_WARN_BIT]) begin
      warn_q <= 1'b0;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL:  rd_mux[CTRL_HALT_BIT] = halt_q;
      OFS_STAT: begin
        rd_mux[3:0]           = state_num_q;
        rd_mux[STAT_WARN_BIT] = warn_q;
        rd_mux[STAT_LOCK_BIT] = lock_q;
        rd_mux[STAT_PA_BIT]   = drv_q.power_amp;
        rd_mux[STAT_QS_BIT]   = drv_q.quick_stop;
        rd_mux[STAT_EN_BIT]   = en_s;
      end
      OFS_CAUSE: rd_mux[15:0] = cause_q;
      OFS_HCNT:  rd_mux[11:0] = {wptr_q, 4'h0, hcnt_q};
      OFS_HSEL:  rd_mux[3:0]  = hsel_q;
      OFS_HDATA: rd_mux[18:0] = hrd;
      default:   rd_ok = 1'b0;
    endcase
  end

  // Read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cls3_off;
    err.valid && (err.cls == CLS_FATAL) |=> !drv_q.power_amp && (state_q == ST_FLT_REACT) ##1 state_q == ST_FAULT;
  endproperty
  a_cls3_off: assert property (p_cls3_off) else $error("class 3 did not switch off");

  property p_lock_hold;
    lock_q && (state_q == ST_FAULT) && !err.valid |=> state_q == ST_FAULT;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("class 4 fault left by reset");

  property p_en_rise;
    (state_q == ST_READY) && en_rise && !hi_err && mon.dcbus_ok && (mon.speed_rpm <= SPD_LIMIT_RPM)
      |=> state_q == ST_SW_ON;
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable edge did not switch on");

  property p_en_fall;
    ((state_q == ST_OP_EN) || (state_q == ST_QSTOP)) && en_fall && !hi_err
      |=> (state_q == ST_SW_DIS) && !drv_q.power_amp;
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable fall kept amplifier on");

  property p_qstop;
    (state_q == ST_OP_EN) && qs_err && !en_fall |=> (state_q == ST_QSTOP) && drv_q.quick_stop && drv_q.power_amp;
  endproperty
  a_qstop: assert property (p_qstop) else $error("class 1 did not quick stop");

  property p_heavy;
    hi_err |=> state_q == ST_FLT_REACT;
  endproperty
  a_heavy: assert property (p_heavy) else $error("heavy error missed fault reaction");

  property p_warn;
    (state_q == ST_OP_EN) && err.valid && (err.cls == CLS_WARN) && !en_fall |=> (state_q == ST_OP_EN) && warn_q;
  endproperty
  a_warn: assert property (p_warn) else $error("warning disturbed motion");

  property p_cause;
    qs_err |=> cause_q == $past(err.code);
  endproperty
  a_cause: assert property (p_cause) else $error("class 1 cause not recorded");

  property p_halt;
    (state_q == ST_OP_EN) && halt_q && !err.valid && !en_fall
      |=> drv_q.motion_stop && drv_q.power_amp && $stable(cause_q) && $stable(wptr_q);
  endproperty
  a_halt: assert property (p_halt) else $error("halt misbehaved");

  property p_resume;
    (state_q == ST_QSTOP) && fr_req && !en_fall && !hi_err |=> state_q == ST_OP_EN;
  endproperty
  a_resume: assert property (p_resume) else $error("fault reset did not resume");

  property p_cls2_wait;
    (state_q == ST_FLT_REACT) && (react_q == CLS_QSOFF) && !mon.standstill && !hi_err |=> state_q == ST_FLT_REACT;
  endproperty
  a_cls2_wait: assert property (p_cls2_wait) else $error("class 2 left before standstill");

  c_run: cover property ((state_q == ST_SW_ON) ##1 (state_q == ST_OP_EN));
  c_qs_back: cover property ((state_q == ST_QSTOP) ##[1:20] (state_q == ST_OP_EN));
  c_fault_rst: cover property ((state_q == ST_FAULT) ##1 (state_q == ST_SW_DIS));
  c_cls2: cover property ((state_q == ST_FLT_REACT) && (react_q == CLS_QSOFF) ##1 (state_q == ST_FAULT));

endmodule

// ---- dsfs_ctrl_model.sv ----
// Model of the external controller that drives enable and fault reset
`timescale 1ns/1ps
module dsfs_ctrl_model (
  input  wire logic aclk,       // Clock
  output logic      enable_pin, // Enable level
  output logic      frst_pin    // Fault reset request
);
  initial begin
    enable_pin = 1'b0;
    frst_pin   = 1'b0;
  end

  // Level change only, caller spaces edges beyond the synchroniser delay
  task automatic set_enable(input logic v);
    @(posedge aclk);
    enable_pin <= v;
  endtask

  // Pulse runs on by itself so the caller can watch the state change
  task automatic fault_reset();
    @(posedge aclk);
    frst_pin <= 1'b1;
    fork
      begin
        repeat (4) @(posedge aclk);
        frst_pin <= 1'b0;
      end
    join_none
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the drive state and fault sequencer
`timescale 1ns/1ps
module testbench
  import dsfs_pkg::*;
;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        enable_pin;
  logic        frst_pin;
  dsfs_mon_t   mon     = '0;
  dsfs_err_t   err     = '0;
  dsfs_drv_t   drv_q;
  logic [3:0]  state_num_q;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic [3:0]  wr_strb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  int          n_mismatch = 0;
  int          tests_run  = 0;

  always #12.5 aclk = ~aclk;

  dsfs_sequencer u_dut (
    .aclk(aclk), .aresetn(aresetn), .enable_pin(enable_pin), .frst_pin(frst_pin),
    .mon(mon), .err(err), .drv_q(drv_q), .state_num_q(state_num_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  dsfs_ctrl_model u_ctrl (.aclk(aclk), .enable_pin(enable_pin), .frst_pin(frst_pin));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= wr_strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    axi_rd(a);
    chk("rresp", 32'(RESP_OKAY), 32'(r));
    chk(nm, e, d);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Bounded wait of up to 30 cycles; pins pass a synchroniser two flops deep
  task automatic expect_state(input logic [3:0] n);
    int i;
    i = 0;
    while (state_num_q !== n && i < 30) begin
      step(1);
      i++;
    end
    chk("state", 32'(n), 32'(state_num_q));
  endtask

  // State and power stage word {pa, brake, qstop, mstop}
  task automatic look(input logic [3:0] n, input logic [3:0] dv);
    chk("state", 32'(n), 32'(state_num_q));
    chk("drv", 32'(dv), 32'(drv_q));
  endtask

  // One-cycle error event; returns just after the edge that samples it
  task automatic send_err(input logic [2:0] c, input logic [15:0] code);
    @(posedge aclk);
    err <= '{1'b1, c, code};
    @(posedge aclk);
    err <= '0;
    #1;
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is well under 4000 cycles
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    step(1);
    look(4'h1, 4'h0);
    rd_chk(OFS_STAT, 32'h1, "stat");
    rd_chk(OFS_CAUSE, 32'h0, "cause");
    mon.init_done <= 1'b1;
    expect_state(4'h2);
    mon.commissioned <= 1'b1;
    expect_state(4'h3);
    mon.enc_ok <= 1'b1;
    mon.dcbus_ok <= 1'b1;
    mon.checks_ok <= 1'b1;
    mon.speed_rpm <= SPD_LIMIT_RPM;
    step(6);
    look(4'h3, 4'h0);
    mon.speed_rpm <= 16'h03e7;
    expect_state(4'h4);
    mon.speed_rpm <= 16'h03e9;
    expect_state(4'h3);
    mon.speed_rpm <= 16'h03e7;
    expect_state(4'h4);
    mon.dcbus_ok <= 1'b0;
    expect_state(4'h3);
    mon.dcbus_ok <= 1'b1;
    expect_state(4'h4);
    u_ctrl.set_enable(1'b1);
    expect_state(4'h6);
    look(4'h6, 4'hc);
    axi_wr(OFS_CTRL, 32'h2);
    step(3);
    look(4'h6, 4'hd);
    rd_chk(OFS_HCNT, 32'h0, "hcnt halt");
    axi_wr(OFS_CTRL, 32'h0);
    step(3);
    look(4'h6, 4'hc);
    send_err(CLS_WARN, 16'h0a01);
    look(4'h6, 4'hc);
    axi_rd(OFS_STAT);
    chk("warn", 32'h1, 32'(d[STAT_WARN_BIT]));
    // Clear needs lane 1; lane 0 alone must leave the flag set
    wr_strb = 4'h1;
    axi_wr(OFS_STAT, 32'h100);
    axi_rd(OFS_STAT);
    chk("warn kept", 32'h1, 32'(d[STAT_WARN_BIT]));
    wr_strb = 4'h2;
    axi_wr(OFS_STAT, 32'h100);
    chk("stat wr", 32'(RESP_OKAY), 32'(r));
    axi_rd(OFS_STAT);
    chk("warn clear", 32'h0, 32'(d[STAT_WARN_BIT]));
    wr_strb = 4'hf;
    rd_chk(OFS_CAUSE, 32'h0, "cause warn");
    send_err(CLS_QSTOP, 16'h0b02);
    look(4'h7, 4'he);
    rd_chk(OFS_CAUSE, 32'h0b02, "cause qs");
    axi_rd(OFS_HCNT);
    chk("hcnt", 32'h2, 32'(d[3:0]));
    // No byte lane: the fault reset bit must not act
    wr_strb = 4'h0;
    axi_wr(OFS_CTRL, 32'h1);
    wr_strb = 4'hf;
    step(4);
    look(4'h7, 4'he);
    axi_wr(OFS_CTRL, 32'h1);
    expect_state(4'h6);
    look(4'h6, 4'hc);
    send_err(CLS_QSTOP, 16'h0b03);
    look(4'h7, 4'he);
    u_ctrl.set_enable(1'b0);
    expect_state(4'h3);
    chk("pa", 32'h0, 32'(drv_q.power_amp));
    u_ctrl.set_enable(1'b1);
    expect_state(4'h6);
    u_ctrl.set_enable(1'b0);
    expect_state(4'h3);
    chk("pa", 32'h0, 32'(drv_q.power_amp));
    u_ctrl.set_enable(1'b1);
    expect_state(4'h6);
    send_err(CLS_QSOFF, 16'h0c04);
    look(4'h8, 4'he);
    mon.standstill <= 1'b1;
    expect_state(4'h9);
    look(4'h9, 4'h0);
    rd_chk(OFS_CAUSE, 32'h0c04, "cause");
    u_ctrl.fault_reset();
    expect_state(4'h3);
    u_ctrl.set_enable(1'b0);
    step(6);
    u_ctrl.set_enable(1'b1);
    expect_state(4'h6);
    send_err(CLS_FATAL, 16'h0d05);
    look(4'h8, 4'h0);
    expect_state(4'h9);
    u_ctrl.fault_reset();
    expect_state(4'h3);
    u_ctrl.set_enable(1'b0);
    step(6);
    u_ctrl.set_enable(1'b1);
    expect_state(4'h6);
    send_err(CLS_UNCTL, 16'h0e06);
    look(4'h8, 4'h0);
    expect_state(4'h9);
    u_ctrl.fault_reset();
    step(10);
    axi_wr(OFS_CTRL, 32'h1);
    step(6);
    look(4'h9, 4'h0);
    axi_rd(OFS_STAT);
    chk("lock", 32'h1, 32'(d[STAT_LOCK_BIT]));
    // Five more entries wrap the ten-slot history once
    for (int i = 0; i < 5; i++) begin
      send_err(CLS_WARN, 16'(16'h0a10 + i));
    end
    rd_chk(OFS_HCNT, 32'h0000010a, "hcnt");
    axi_wr(OFS_HSEL, 32'h1);
    rd_chk(OFS_HDATA, 32'h00010b02, "hdata1");
    axi_wr(OFS_HSEL, 32'h0);
    rd_chk(OFS_HDATA, 32'h00000a14, "hdata0");
    axi_rd(8'h40);
    chk("unmapped", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    axi_wr(OFS_CAUSE, 32'hffff);
    chk("ro write", 32'(RESP_SLVERR), 32'(r));
    rd_chk(OFS_CAUSE, 32'h0e06, "cause");
    @(posedge aclk);
    aresetn <= 1'b0;
    mon.init_done <= 1'b0;
    mon.speed_low <= 1'b1;
    step(2);
    look(4'h1, 4'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFS_STAT);
    chk("lock", 32'h0, 32'(d[STAT_LOCK_BIT]));
    rd_chk(OFS_HCNT, 32'h0, "hcnt rst");
    // Low speed alone must leave start
    expect_state(4'h4);
    report_and_stop();
  end
endmodule
